// ===== smd_datapath.sv
// Subtract datapath for the two memory-operand subtract instructions
// Behaviour
// RULE1: Subtract-into-work-register writes work register minus memory byte.
// RULE2: A borrow from the subtraction clears the carry flag to zero.
// RULE3: No borrow from the subtraction sets the carry flag to one.
// RULE4: Subtract-into-memory stores the difference to the addressed byte.
// RULE5: Both update zero, signed range and half-byte borrow flags too.
`default_nettype none
`include "smd_defines.svh"
module smd_datapath #(
  parameter int DATA_W = `SMD_DATA_W,
  parameter int ADDR_W = `SMD_ADDR_W
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_op_valid,
  input wire smd_pkg::smd_op_t i_op_kind,
  input wire logic [ADDR_W-1:0] i_mem_addr,
  input wire logic [DATA_W-1:0] i_mem_data,
  input wire logic i_work_load,
  input wire logic [DATA_W-1:0] i_work_load_data,
  output logic [DATA_W-1:0] o_work_register,
  output logic o_carry_flag,
  output logic o_zero_flag,
  output logic o_half_byte_borrow_flag,
  output logic o_signed_range_flag,
  output logic o_mem_wr_en,
  output logic [ADDR_W-1:0] o_mem_wr_addr,
  output logic [DATA_W-1:0] o_mem_wr_data,
  output logic o_done
);
  import smd_pkg::*;

  if (DATA_W < `SMD_MIN_DATA_W) begin : g_width_check
    $error("DATA_W too small for half-byte borrow");
  end
  if (ADDR_W < 1) begin : g_addr_check
    $error("ADDR_W must be at least one");
  end

  logic [DATA_W-1:0] work_q;
  logic [DATA_W-1:0] work_d;
  logic carry_q;
  logic carry_d;
  logic zero_q;
  logic zero_d;
  logic half_q;
  logic half_d;
  logic range_q;
  logic range_d;
  logic mem_we_q;
  logic mem_we_d;
  logic [ADDR_W-1:0] mem_addr_q;
  logic [ADDR_W-1:0] mem_addr_d;
  logic [DATA_W-1:0] mem_data_q;
  logic [DATA_W-1:0] mem_data_d;
  logic done_q;
  logic done_d;

  logic [DATA_W-1:0] diff;
  logic no_borrow;
  logic half_no_borrow;
  logic signed_over;
  logic diff_zero;

  // Work register is always the minuend, memory byte the subtrahend
  smd_subtractor #(
    .DATA_W(DATA_W)
  ) u_subtractor (
    .i_minuend(work_q),
    .i_subtrahend(i_mem_data),
    .o_difference(diff),
    .o_no_borrow(no_borrow),
    .o_half_no_borrow(half_no_borrow),
    .o_signed_over(signed_over),
    .o_zero(diff_zero)
  );

  // Next state; an instruction wins over a work register load
  always_comb begin
    work_d = work_q;
    carry_d = carry_q;
    zero_d = zero_q;
    half_d = half_q;
    range_d = range_q;
    mem_we_d = `SMD_FLAG_RST;
    mem_addr_d = mem_addr_q;
    mem_data_d = mem_data_q;
    done_d = `SMD_FLAG_RST;
    if (i_op_valid) begin
      carry_d = no_borrow ? `SMD_FLAG_SET : `SMD_FLAG_RST; // RULE2 RULE3
      zero_d = diff_zero; // RULE5
      half_d = half_no_borrow; // RULE5
      range_d = signed_over; // RULE5
      done_d = `SMD_FLAG_SET;
      unique case (i_op_kind)
        SMD_OP_SUB_WORK: begin
          work_d = diff; // RULE1
        end
        SMD_OP_SUB_MEM: begin
          mem_we_d = `SMD_FLAG_SET; // RULE4
          mem_addr_d = i_mem_addr; // RULE4
          mem_data_d = diff; // RULE4
        end
      endcase
    end else if (i_work_load) begin
      work_d = i_work_load_data;
    end
  end

  // Register stage
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      work_q <= DATA_W'(`SMD_WORK_RST);
      carry_q <= `SMD_FLAG_RST;
      zero_q <= `SMD_FLAG_RST;
      half_q <= `SMD_FLAG_RST;
      range_q <= `SMD_FLAG_RST;
      mem_we_q <= `SMD_FLAG_RST;
      mem_addr_q <= ADDR_W'(`SMD_ADDR_RST);
      mem_data_q <= DATA_W'(`SMD_WORK_RST);
      done_q <= `SMD_FLAG_RST;
    end else begin
      work_q <= work_d;
      carry_q <= carry_d;
      zero_q <= zero_d;
      half_q <= half_d;
      range_q <= range_d;
      mem_we_q <= mem_we_d;
      mem_addr_q <= mem_addr_d;
      mem_data_q <= mem_data_d;
      done_q <= done_d;
    end
  end

  assign o_work_register = work_q;
  assign o_carry_flag = carry_q;
  assign o_zero_flag = zero_q;
  assign o_half_byte_borrow_flag = half_q;
  assign o_signed_range_flag = range_q;
  assign o_mem_wr_en = mem_we_q;
  assign o_mem_wr_addr = mem_addr_q;
  assign o_mem_wr_data = mem_data_q;
  assign o_done = done_q;

  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  logic sub_work;
  logic sub_mem;
  assign sub_work = i_op_valid && (i_op_kind == SMD_OP_SUB_WORK);
  assign sub_mem = i_op_valid && (i_op_kind == SMD_OP_SUB_MEM);

  // Reference difference kept apart from the subtractor instance
  logic [DATA_W-1:0] chk_diff;
  assign chk_diff = o_work_register - i_mem_data;

  work_result_a: assert property ( // RULE1
    sub_work |=> o_work_register
      == DATA_W'($past(o_work_register) - $past(i_mem_data))
      && !o_mem_wr_en && o_done)
    else $error("work register difference wrong");

  carry_clear_a: assert property ( // RULE2
    i_op_valid && (i_mem_data > o_work_register) |=> !o_carry_flag)
    else $error("carry not cleared on borrow");

  carry_set_a: assert property ( // RULE3
    i_op_valid && (i_mem_data <= o_work_register) |=> o_carry_flag)
    else $error("carry not set without borrow");

  mem_write_a: assert property ( // RULE4
    sub_mem |=> o_mem_wr_en && o_mem_wr_addr == $past(i_mem_addr)
      && o_mem_wr_data
      == DATA_W'($past(o_work_register) - $past(i_mem_data))
      && $stable(o_work_register))
    else $error("memory write of difference wrong");

  mem_pulse_a: assert property ( // RULE4
    o_mem_wr_en |=> !o_mem_wr_en || $past(sub_mem))
    else $error("memory write not a single pulse");

  mem_hold_a: assert property ( // RULE4
    !sub_mem |=> !o_mem_wr_en && $stable(o_mem_wr_addr)
      && $stable(o_mem_wr_data))
    else $error("memory write outputs changed without an instruction");

  work_load_a: assert property (
    i_work_load && !i_op_valid |=> o_work_register == $past(i_work_load_data))
    else $error("work register load wrong");

  work_hold_a: assert property (
    !i_op_valid && !i_work_load |=> $stable(o_work_register))
    else $error("work register changed while idle");

  zero_flag_a: assert property ( // RULE5
    i_op_valid && (i_mem_data == o_work_register) |=> o_zero_flag
      ##1 (o_zero_flag || $past(i_op_valid)))
    else $error("zero flag wrong");

  half_borrow_a: assert property ( // RULE5
    i_op_valid |=> o_half_byte_borrow_flag
      == ($past(i_mem_data[`SMD_NIBBLE_W-1:0])
      <= $past(o_work_register[`SMD_NIBBLE_W-1:0])))
    else $error("half-byte borrow flag wrong");

  signed_range_a: assert property ( // RULE5
    i_op_valid |=> o_signed_range_flag
      == (($past(o_work_register[DATA_W-1])
      != $past(i_mem_data[DATA_W-1]))
      && ($past(o_work_register[DATA_W-1])
      != $past(chk_diff[DATA_W-1]))))
    else $error("signed range flag wrong");

  flags_hold_a: assert property ( // RULE5
    !i_op_valid |=> $stable(o_carry_flag) && $stable(o_zero_flag)
      && $stable(o_half_byte_borrow_flag)
      && $stable(o_signed_range_flag) && !o_done)
    else $error("flags changed without an instruction");

  sub_work_c: cover property (sub_work ##1 sub_work);
  sub_mem_c: cover property (sub_mem && i_mem_data > o_work_register);
  overflow_c: cover property (i_op_valid ##1 o_signed_range_flag);
  load_then_sub_c: cover property (i_work_load ##1 sub_mem);
  zero_result_c: cover property (sub_work ##1 o_zero_flag);
endmodule
`default_nettype wire

// ===== smd_defines.svh
// Constants for the subtract-from-memory datapath
`ifndef SMD_DEFINES_SVH
`define SMD_DEFINES_SVH
`define SMD_DATA_W 8
`define SMD_ADDR_W 5
`define SMD_MIN_DATA_W 5
`define SMD_NIBBLE_W 4
`define SMD_WORK_RST 8'h00
`define SMD_ADDR_RST 5'h00
`define SMD_FLAG_RST 1'h0
`define SMD_FLAG_SET 1'h1
`define SMD_ONE_BIT 1'h1
`endif

// ===== smd_pkg.sv
// Types shared by the subtract-from-memory datapath
`default_nettype none
package smd_pkg;
  typedef enum logic {
    SMD_OP_SUB_WORK,
    SMD_OP_SUB_MEM
  } smd_op_t;
endpackage
`default_nettype wire

// ===== smd_subtractor.sv
// Combinational subtractor with borrow-style flags
`default_nettype none
`include "smd_defines.svh"
module smd_subtractor #(
  parameter int DATA_W = `SMD_DATA_W
) (
  input wire logic [DATA_W-1:0] i_minuend,
  input wire logic [DATA_W-1:0] i_subtrahend,
  output logic [DATA_W-1:0] o_difference,
  output logic o_no_borrow,
  output logic o_half_no_borrow,
  output logic o_signed_over,
  output logic o_zero
);
  logic [DATA_W:0] full_sum;
  logic [`SMD_NIBBLE_W:0] half_sum;

  // Two's complement subtraction: carry out high means no borrow
  assign full_sum = {1'h0, i_minuend} + {1'h0, ~i_subtrahend}
                    + {{DATA_W{1'h0}}, `SMD_ONE_BIT};
  assign half_sum = {1'h0, i_minuend[`SMD_NIBBLE_W-1:0]}
                    + {1'h0, ~i_subtrahend[`SMD_NIBBLE_W-1:0]}
                    + {{`SMD_NIBBLE_W{1'h0}}, `SMD_ONE_BIT};
  assign o_difference = full_sum[DATA_W-1:0];
  assign o_no_borrow = full_sum[DATA_W];
  assign o_half_no_borrow = half_sum[`SMD_NIBBLE_W];
  assign o_signed_over = (i_minuend[DATA_W-1] != i_subtrahend[DATA_W-1])
                         && (full_sum[DATA_W-1] != i_minuend[DATA_W-1]);
  assign o_zero = (full_sum[DATA_W-1:0] == '0);
endmodule
`default_nettype wire

// ===== smd_mem_model.sv
// Data memory model on the far side of the subtract datapath
`default_nettype none
module smd_mem_model #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 5
) (
  input wire logic i_clock,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [DATA_W-1:0] o_rd_data,
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem_q [2**ADDR_W];
  assign o_rd_data = mem_q[i_rd_addr];
  always @(posedge i_clock) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the subtract datapath
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import smd_pkg::*;
  logic i_clock = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  smd_op_t op_kind = SMD_OP_SUB_WORK;
  logic [4:0] mem_addr = 5'h00;
  logic [7:0] mem_data;
  logic work_load = 1'b0;
  logic [7:0] load_data = 8'h00;
  logic [7:0] work, wr_data;
  logic carry, zero, half, ovf, wr_en, done;
  logic [4:0] wr_addr;
  logic [7:0] exp_work = 8'h00;
  int n_mismatch = 0;
  int cmp_count = 0;
  smd_datapath dut (.i_clock(i_clock), .i_reset_n(rst_n),
    .i_op_valid(op_valid), .i_op_kind(op_kind), .i_mem_addr(mem_addr),
    .i_mem_data(mem_data), .i_work_load(work_load),
    .i_work_load_data(load_data), .o_work_register(work),
    .o_carry_flag(carry), .o_zero_flag(zero),
    .o_half_byte_borrow_flag(half), .o_signed_range_flag(ovf),
    .o_mem_wr_en(wr_en), .o_mem_wr_addr(wr_addr),
    .o_mem_wr_data(wr_data), .o_done(done));
  smd_mem_model mem (.i_clock(i_clock), .i_rd_addr(mem_addr),
    .o_rd_data(mem_data), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data));
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  task automatic check_byte(input string nm, input logic [7:0] e,
                            input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_bit(input string nm, input logic e, input logic g);
    check_byte(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic load(input logic [7:0] d);
    op_valid = 1'b0;
    work_load = 1'b1;
    load_data = d;
    @(negedge i_clock);
    work_load = 1'b0;
    exp_work = d;
    check_byte("load", d, work);
  endtask
  task automatic issue(input smd_op_t k, input logic [4:0] ad,
                       input logic [7:0] m);
    logic [7:0] a;
    logic [7:0] d;
    a = exp_work;
    d = a - m;
    mem.mem_q[ad] = m;
    op_kind = k;
    mem_addr = ad;
    op_valid = 1'b1;
    @(negedge i_clock);
    check_bit("done", 1'b1, done);
    check_bit("carry", a >= m, carry);
    check_bit("zero", d == 8'h00, zero);
    check_bit("half", a[3:0] >= m[3:0], half);
    check_bit("ovf", (a[7] != m[7]) && (d[7] != a[7]), ovf);
    check_bit("wr_en", k == SMD_OP_SUB_MEM, wr_en);
    if (k == SMD_OP_SUB_WORK) exp_work = d;
    check_byte("work", exp_work, work);
    if (k == SMD_OP_SUB_MEM) begin
      check_byte("wr_data", d, wr_data);
      check_byte("wr_addr", {3'h0, ad}, {3'h0, wr_addr});
    end
  endtask
  task automatic test_flags();
    logic [7:0] av [6] = '{8'h05, 8'h03, 8'h42, 8'h10, 8'h80, 8'h7F};
    logic [7:0] mv [6] = '{8'h03, 8'h05, 8'h42, 8'h01, 8'h01, 8'hFF};
    for (int i = 0; i < 6; i++) begin
      load(av[i]);
      issue(SMD_OP_SUB_WORK, 5'h02, mv[i]);
      load(av[i]);
      issue(SMD_OP_SUB_MEM, 5'h03, mv[i]);
    end
    $display("end of test: flags");
  endtask
  task automatic test_mem();
    load(8'h20);
    issue(SMD_OP_SUB_MEM, 5'h1F, 8'h01);
    op_valid = 1'b0;
    @(negedge i_clock);
    check_byte("mem", 8'h1F, mem.mem_q[31]);
    check_bit("done_end", 1'b0, done);
    check_bit("wr_end", 1'b0, wr_en);
    $display("end of test: mem");
  endtask
  task automatic test_b2b();
    load(8'h30);
    issue(SMD_OP_SUB_WORK, 5'h04, 8'h10);
    issue(SMD_OP_SUB_WORK, 5'h05, 8'h10);
    issue(SMD_OP_SUB_MEM, 5'h06, 8'h05);
    issue(SMD_OP_SUB_WORK, 5'h07, 8'h11);
    op_valid = 1'b0;
    $display("end of test: back_to_back");
  endtask
  task automatic test_ignore();
    load(8'h09);
    work_load = 1'b1;
    load_data = 8'hEE;
    issue(SMD_OP_SUB_WORK, 5'h08, 8'h01);
    op_valid = 1'b0;
    @(negedge i_clock);
    work_load = 1'b0;
    check_byte("late_load", 8'hEE, work);
    exp_work = 8'hEE;
    rst_n = 1'b0;
    #1;
    check_byte("rst_work", 8'h00, work);
    check_bit("rst_carry", 1'b0, carry);
    exp_work = 8'h00;
    @(negedge i_clock);
    rst_n = 1'b1;
    $display("end of test: ignore_and_reset");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    foreach (mem.mem_q[i]) mem.mem_q[i] = 8'h00;
    repeat (4) @(negedge i_clock);
    check_byte("reset_work", 8'h00, work);
    check_bit("reset_done", 1'b0, done);
    rst_n = 1'b1;
    test_flags();
    test_mem();
    test_b2b();
    test_ignore();
    test_b2b();
    conclude();
  end
endmodule
`default_nettype wire
